// ==== design/pof_consts.svh ====
// Function
// [R1] Subindex zero of shaft revolution array reads the feedback count, preset three.
// [R2] Subindex n holds a writable 32-bit revolution count; subindex one is sensorless.
// [R3] Feed constant of feedback n is feed n divided by revolutions n.
// [R4] Option word is 16-bit read/write, preset 0001, with the listed fields.
// [R5] Relative code 00 uses previous absolute target, or zero if none.
// [R6] Relative code 01 uses ramp output, 10 actual position, 11 reserved.
// [R7] Self release clears new-setpoint bit, then clears setpoint acknowledge.
// [R8] Release code 00 master handshake, 01 at target, 10 at once, 11 reserved.
// [R9] Rotary code 00 behaves linear; only it allows moves beyond modulo value.
// [R10] Rotary code 01 moves negative only, through minimum limit if needed.
// [R11] Rotary code 10 moves positive only, through maximum limit if needed.
// [R12] Rotary code 11 takes shortest path; under half a turn goes positive.
// [R13] Option word is sampled when a new setpoint is accepted.
`ifndef POF_CONSTS_SVH
`define POF_CONSTS_SVH
`define POF_IDX_SHAFT_REV 16'h60EE
`define POF_IDX_POS_OPT 16'h60F2
`define POF_NUM_FB 8'h03
`define POF_SHAFT_REV_RST 32'h00000001
`define POF_POS_OPT_RST 16'h0001
`define POF_REL_LSB 0
`define POF_RELEASE_LSB 4
`define POF_ROTARY_LSB 6
`define POF_CW_NEW_SP 4
`define POF_CW_RELATIVE 6
`define POF_SW_SP_ACK 12
`endif

// ==== design/pof_pkg.sv ====
package pof_pkg;
    typedef enum logic [1:0] {
        POF_REL_PREV, POF_REL_RAMP, POF_REL_ACTUAL, POF_REL_RSVD
    } pof_rel_e;
    typedef enum logic [1:0] {
        POF_RR_MASTER, POF_RR_AT_TARGET, POF_RR_AT_ONCE, POF_RR_RSVD
    } pof_rr_e;
    typedef enum logic [1:0] {
        POF_DIR_LINEAR, POF_DIR_NEG, POF_DIR_POS, POF_DIR_SHORT
    } pof_dir_e;
    typedef enum logic [1:0] {
        POF_HS_IDLE, POF_HS_ACK, POF_HS_REL, POF_HS_WAIT_LOW
    } pof_hs_e;
endpackage : pof_pkg

// ==== design/pof_div.sv ====
`timescale 1ns/10ps
module pof_div #(
    parameter int W = 32
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Request
    input wire logic start_i,
    input wire logic [W-1:0] num_i,
    input wire logic [W-1:0] den_i,
    // Result
    output logic busy_o,
    output logic done_o,
    output logic [W-1:0] quot_o
);
    import pof_pkg::*;
    localparam int CW = $clog2(W) + 1;
    typedef struct packed {
        logic busy;
        logic done;
        logic [CW-1:0] cnt;
        logic [W:0] rem;
        logic [W-1:0] quo;
        logic [W-1:0] den;
    } pof_div_s;
    pof_div_s s_q, s_d;
    logic [W:0] trial;

    // One quotient bit per cycle keeps the area small; W cycles per result
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        trial = {s_q.rem[W-1:0], s_q.quo[W-1]};
        if (start_i && !s_q.busy) begin
            s_d.busy = 1'b1;
            s_d.cnt = CW'(W);
            s_d.rem = '0;
            s_d.quo = num_i;
            s_d.den = den_i;
        end else if (s_q.busy) begin
            if (trial >= {1'b0, s_q.den}) begin
                s_d.rem = trial - {1'b0, s_q.den};
                s_d.quo = {s_q.quo[W-2:0], 1'b1};
            end else begin
                s_d.rem = trial;
                s_d.quo = {s_q.quo[W-2:0], 1'b0};
            end
            s_d.cnt = s_q.cnt - CW'(1);
            if (s_q.cnt == CW'(1)) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy_o = s_q.busy;
    assign done_o = s_q.done;
    assign quot_o = s_q.quo;
endmodule : pof_div

// ==== design/pof_top.sv ====
`timescale 1ns/10ps
`include "pof_consts.svh"
module pof_top #(
    parameter int NUM_FB = 3
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Object dictionary access
    input wire logic od_req_i,
    input wire logic od_we_i,
    input wire logic [15:0] od_index_i,
    input wire logic [7:0] od_sub_i,
    input wire logic [31:0] od_wdata_i,
    output logic od_ack_o,
    output logic od_abort_o,
    output logic [31:0] od_rdata_o,
    // Controlword and statusword
    input wire logic pp_mode_i,
    input wire logic [15:0] controlword_i,
    output logic new_sp_release_o,
    output logic setpoint_ack_o,
    output logic setpoint_reject_o,
    // Positions
    input wire logic [31:0] target_pos_i,
    input wire logic [31:0] actual_pos_i,
    input wire logic [31:0] ramp_pos_i,
    input wire logic [31:0] range_min_i,
    input wire logic [31:0] range_max_i,
    input wire logic target_reached_i,
    // Move command
    output logic move_valid_o,
    output logic [31:0] move_target_o,
    output logic move_dir_pos_o,
    output logic move_via_limit_o,
    output logic move_linear_o,
    // Feed constant
    input wire logic fc_start_i,
    input wire logic [7:0] fc_sel_i,
    input wire logic [31:0] fc_feed_i,
    output logic fc_busy_o,
    output logic fc_valid_o,
    output logic fc_div_zero_o,
    output logic [31:0] fc_value_o
);
    import pof_pkg::*;

    typedef struct packed {
        logic [NUM_FB-1:0][31:0] shaft_rev;
        logic [15:0] pos_opt;
        logic [15:0] opt_used;
        logic ack;
        logic abort;
        logic [31:0] rdata;
        pof_hs_e hs;
        logic new_sp_prev;
        logic release_p;
        logic reject_p;
        logic prev_valid;
        logic [31:0] prev_target;
        logic move_valid;
        logic [31:0] move_target;
        logic dir_pos;
        logic via_limit;
        logic linear;
        logic fc_run;
        logic fc_zero;
        logic fc_valid;
        logic [31:0] fc_value;
        logic [31:0] fc_num;
        logic [31:0] fc_den;
    } pof_top_s;

    pof_top_s s_q, s_d;

    // Array subindex decode shared by read and write paths
    function automatic logic fb_hit(input logic [7:0] sub);
        fb_hit = (sub != 8'h00) && (sub <= 8'(NUM_FB));
    endfunction : fb_hit

    function automatic int fb_slot(input logic [7:0] sub);
        fb_slot = int'(sub) - 1;
    endfunction : fb_slot

    logic new_sp;
    logic relative;
    logic accept;
    logic [1:0] rel_code;
    logic [1:0] rr_code;
    logic [1:0] dir_code;
    logic [31:0] base;
    logic [31:0] abs_tgt;
    logic [31:0] span;
    logic [31:0] diff;
    logic div_start;
    logic div_busy;
    logic div_done;
    logic [31:0] div_quot;

    assign new_sp = controlword_i[`POF_CW_NEW_SP];
    assign relative = controlword_i[`POF_CW_RELATIVE];
    assign rel_code = s_q.pos_opt[`POF_REL_LSB +: 2];
    assign rr_code = s_q.pos_opt[`POF_RELEASE_LSB +: 2];
    assign dir_code = s_q.pos_opt[`POF_ROTARY_LSB +: 2];
    assign accept = pp_mode_i && new_sp && !s_q.new_sp_prev
        && (s_q.hs == POF_HS_IDLE);

    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.abort = 1'b0;
        s_d.release_p = 1'b0;
        s_d.reject_p = 1'b0;
        s_d.move_valid = 1'b0;
        s_d.fc_valid = 1'b0;
        s_d.new_sp_prev = new_sp;
        base = 32'h00000000;
        abs_tgt = 32'h00000000;
        span = range_max_i - range_min_i;
        diff = 32'h00000000;
        div_start = 1'b0;

        // Object dictionary access, answered one cycle after the request
        if (od_req_i) begin
            s_d.ack = 1'b1;
            s_d.rdata = 32'h00000000;
            if (od_index_i == `POF_IDX_SHAFT_REV) begin
                if (od_sub_i == 8'h00) begin
                    s_d.rdata = {24'h000000, 8'(NUM_FB)}; // [R1]
                    s_d.abort = od_we_i; // [R1]
                end else if (fb_hit(od_sub_i)) begin
                    if (od_we_i) begin
                        s_d.shaft_rev[fb_slot(od_sub_i)] = od_wdata_i; // [R2]
                    end else begin
                        s_d.rdata = s_q.shaft_rev[fb_slot(od_sub_i)]; // [R2]
                    end
                end else begin
                    s_d.abort = 1'b1;
                end
            end else if (od_index_i == `POF_IDX_POS_OPT
                    && od_sub_i == 8'h00) begin
                if (od_we_i) begin
                    s_d.pos_opt = od_wdata_i[15:0]; // [R4]
                end else begin
                    s_d.rdata = {16'h0000, s_q.pos_opt}; // [R4]
                end
            end else begin
                s_d.abort = 1'b1;
            end
        end

        // Reference for a relative move
        case (pof_rel_e'(rel_code))
            POF_REL_PREV: base = s_q.prev_valid ? s_q.prev_target
                : 32'h00000000; // [R5]
            POF_REL_RAMP: base = ramp_pos_i; // [R6]
            POF_REL_ACTUAL: base = actual_pos_i; // [R6]
            default: base = 32'h00000000;
        endcase
        abs_tgt = relative ? base + target_pos_i : target_pos_i; // [R5]
        diff = abs_tgt - actual_pos_i;
        if ($signed(diff) < 0) begin
            diff = diff + span; // [R12]
        end

        // Setpoint handshake
        case (s_q.hs)
            POF_HS_IDLE: begin
                if (accept) begin
                    // Reserved codes are refused so no undefined move starts
                    if ((relative && rel_code == 2'b11)
                            || rr_code == 2'b11) begin
                        s_d.reject_p = 1'b1; // [R6] [R8]
                    end else begin
                        s_d.opt_used = s_q.pos_opt; // [R13]
                        s_d.hs = POF_HS_ACK;
                        s_d.move_valid = 1'b1;
                        s_d.move_target = abs_tgt;
                        s_d.prev_target = abs_tgt; // [R5]
                        s_d.prev_valid = 1'b1;
                        s_d.linear = 1'b0;
                        s_d.via_limit = 1'b0;
                        case (pof_dir_e'(dir_code))
                            POF_DIR_LINEAR: begin
                                s_d.linear = 1'b1; // [R9]
                                s_d.dir_pos = $signed(abs_tgt)
                                    >= $signed(actual_pos_i); // [R9]
                            end
                            POF_DIR_NEG: begin
                                s_d.dir_pos = 1'b0; // [R10]
                                s_d.via_limit = $signed(abs_tgt)
                                    > $signed(actual_pos_i); // [R10]
                            end
                            POF_DIR_POS: begin
                                s_d.dir_pos = 1'b1; // [R11]
                                s_d.via_limit = $signed(abs_tgt)
                                    < $signed(actual_pos_i); // [R11]
                            end
                            default: begin
                                s_d.dir_pos = diff < (span >> 1); // [R12]
                            end
                        endcase
                    end
                end
            end
            POF_HS_ACK: begin
                case (pof_rr_e'(s_q.opt_used[`POF_RELEASE_LSB +: 2]))
                    POF_RR_MASTER: begin
                        if (!new_sp) begin
                            s_d.hs = POF_HS_IDLE; // [R8]
                        end
                    end
                    POF_RR_AT_TARGET: begin
                        if (target_reached_i) begin
                            s_d.hs = POF_HS_REL; // [R8]
                        end
                    end
                    default: s_d.hs = POF_HS_REL; // [R8]
                endcase
            end
            POF_HS_REL: begin
                s_d.release_p = 1'b1; // [R7]
                s_d.hs = POF_HS_WAIT_LOW;
            end
            POF_HS_WAIT_LOW: begin
                // Acknowledge held one more cycle by the release pulse; wait for the bit to drop
                if (!new_sp) begin
                    s_d.hs = POF_HS_IDLE; // [R7]
                end
            end
            default: s_d.hs = POF_HS_IDLE;
        endcase

        // Feed constant: feed divided by driving shaft revolutions
        if (!s_q.fc_run && fc_start_i && fb_hit(fc_sel_i) && !div_busy) begin
            s_d.fc_run = 1'b1;
            s_d.fc_num = fc_feed_i;
            s_d.fc_den = s_q.shaft_rev[fb_slot(fc_sel_i)]; // [R3]
            s_d.fc_zero = s_q.shaft_rev[fb_slot(fc_sel_i)] == 32'h00000000;
            div_start = 1'b1;
        end
        if (s_q.fc_run && div_done) begin
            s_d.fc_run = 1'b0;
            s_d.fc_valid = 1'b1;
            // Divide by zero saturates instead of leaving a stale value
            s_d.fc_value = s_q.fc_zero ? 32'hFFFFFFFF : div_quot; // [R3]
        end
    end

    pof_div #(
        .W(32)
    ) u_div (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .start_i(div_start),
        .num_i(s_d.fc_num),
        .den_i(s_d.fc_den),
        .busy_o(div_busy),
        .done_o(div_done),
        .quot_o(div_quot)
    );

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
            for (int i = 0; i < NUM_FB; i++) begin
                s_q.shaft_rev[i] <= `POF_SHAFT_REV_RST; // [R2]
            end
            s_q.pos_opt <= `POF_POS_OPT_RST; // [R4]
            s_q.opt_used <= `POF_POS_OPT_RST;
            s_q.hs <= POF_HS_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign od_ack_o = s_q.ack;
    assign od_abort_o = s_q.abort;
    assign od_rdata_o = s_q.rdata;
    assign new_sp_release_o = s_q.release_p; // [R7]
    // Acknowledge stands through the release pulse and drops the cycle after it; under master release it drops the cycle after bit 4 clears
    assign setpoint_ack_o = (s_q.hs == POF_HS_ACK)
        || (s_q.hs == POF_HS_REL) || s_q.release_p; // [R7]
    assign setpoint_reject_o = s_q.reject_p;
    assign move_valid_o = s_q.move_valid;
    assign move_target_o = s_q.move_target;
    assign move_dir_pos_o = s_q.dir_pos;
    assign move_via_limit_o = s_q.via_limit;
    assign move_linear_o = s_q.linear;
    assign fc_busy_o = s_q.fc_run;
    assign fc_valid_o = s_q.fc_valid;
    assign fc_div_zero_o = s_q.fc_zero;
    assign fc_value_o = s_q.fc_value;
endmodule : pof_top

// ==== verification/pof_monitor.sv ====
`timescale 1ns/10ps
module pof_monitor #(
    parameter int NUM_FB = 3
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Object access
    input wire logic od_req_i,
    input wire logic od_we_i,
    input wire logic [15:0] od_index_i,
    input wire logic [7:0] od_sub_i,
    input wire logic od_ack_o,
    input wire logic od_abort_o,
    input wire logic [31:0] od_rdata_o,
    // Handshake and feed
    input wire logic pp_mode_i,
    input wire logic new_sp_release_o,
    input wire logic setpoint_ack_o,
    input wire logic setpoint_reject_o,
    input wire logic move_valid_o,
    input wire logic fc_start_i,
    input wire logic [7:0] fc_sel_i,
    input wire logic fc_busy_o,
    input wire logic fc_valid_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_ack_next: assert property (od_req_i |=> od_ack_o)
        else $error("object access not answered");
    a_ack_cause: assert property (od_ack_o |-> $past(od_req_i))
        else $error("answer without access");
    a_abort_pair: assert property (od_abort_o |-> od_ack_o)
        else $error("abort without answer");
    a_count_read: assert property (od_req_i && !od_we_i
        && od_index_i == 16'h60EE && od_sub_i == 8'h00
        |=> od_rdata_o == 32'(NUM_FB) && !od_abort_o)
        else $error("entry count wrong");
    a_count_ro: assert property (od_req_i && od_we_i
        && od_index_i == 16'h60EE && od_sub_i == 8'h00 |=> od_abort_o)
        else $error("entry count written");
    a_opt_upper: assert property (od_req_i && !od_we_i
        && od_index_i == 16'h60F2 && od_sub_i == 8'h00
        |=> od_rdata_o[31:16] == 16'h0000 && !od_abort_o)
        else $error("option word upper half set");
    a_feed_time: assert property (fc_start_i && !fc_busy_o
        && fc_sel_i inside {[8'h01:8'h03]} |-> ##[33:34] fc_valid_o)
        else $error("feed constant late");
    a_busy_run: assert property (fc_start_i && !fc_busy_o
        && fc_sel_i inside {[8'h01:8'h03]} |=> fc_busy_o)
        else $error("feed constant not started");
    a_release_drop: assert property (new_sp_release_o
        |-> setpoint_ack_o ##1 !setpoint_ack_o)
        else $error("acknowledge not cleared after release");
    a_move_ack: assert property (move_valid_o |-> setpoint_ack_o)
        else $error("move without acknowledge");
    a_reject_alone: assert property (setpoint_reject_o
        |-> !setpoint_ack_o && !move_valid_o)
        else $error("reserved code accepted");
    a_mode_gate: assert property (!pp_mode_i
        |=> !move_valid_o && !setpoint_reject_o)
        else $error("setpoint taken outside profile mode");
endmodule : pof_monitor

bind pof_top pof_monitor #(.NUM_FB(NUM_FB)) u_mon (.sys_clk_i, .rst_n_i,
    .od_req_i, .od_we_i, .od_index_i, .od_sub_i, .od_ack_o, .od_abort_o,
    .od_rdata_o, .pp_mode_i, .new_sp_release_o, .setpoint_ack_o,
    .setpoint_reject_o,
    .move_valid_o, .fc_start_i, .fc_sel_i, .fc_busy_o, .fc_valid_o);

// ==== verification/pof_master_model.sv ====
`timescale 1ns/10ps
module pof_master_model (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Requests
    input wire logic set_i,
    input wire logic clr_i,
    input wire logic release_i,
    // Controlword bit 4
    output logic new_sp_o
);
    // Release wins over a new request arriving in the same cycle
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || clr_i || release_i) begin
            new_sp_o <= 1'b0;
        end else if (set_i) begin
            new_sp_o <= 1'b1;
        end
    end
endmodule : pof_master_model

// ==== verification/pof_top_test.sv ====
`timescale 1ns/10ps
module pof_top_test;
    localparam logic [31:0] ACT = 32'h000003E8;
    localparam logic [31:0] RMP = 32'h000004B0;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic pp = 1'b1;
    logic req = 0, we = 0, set = 0, clr = 0, rf = 0, fcs = 0, tr = 0;
    logic [15:0] idx = 0;
    logic [7:0] sub = 0, fsel = 0;
    logic [31:0] wd = 0, tgt = 0, feed = 0, prev = 0, lf = 32'h0000004E;
    logic [31:0] rv [1:3];
    logic ack, abt, nsp, rls, sack, srej, mv, mdir, mvia, mlin, fb, fval, fdz;
    logic [31:0] rd, mtgt, fv;
    logic [15:0] cw;
    logic [33:0] on;
    logic [32:0] fn;
    logic [36:0] mn;
    logic [33:0] od_q [$];
    logic [32:0] fc_q [$];
    logic [36:0] mv_q [$];
    int failures = 0;
    int comparisons = 0;
    assign cw = {9'h000, rf, 1'b0, nsp, 4'h0};
    pof_top #(.NUM_FB(3)) u_dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
        .od_req_i(req), .od_we_i(we), .od_index_i(idx), .od_sub_i(sub),
        .od_wdata_i(wd), .od_ack_o(ack), .od_abort_o(abt), .od_rdata_o(rd),
        .pp_mode_i(pp), .controlword_i(cw), .new_sp_release_o(rls),
        .setpoint_ack_o(sack), .setpoint_reject_o(srej),
        .target_pos_i(tgt), .actual_pos_i(ACT), .ramp_pos_i(RMP),
        .range_min_i(32'h00000000), .range_max_i(32'h00000E10),
        .target_reached_i(tr), .move_valid_o(mv), .move_target_o(mtgt),
        .move_dir_pos_o(mdir), .move_via_limit_o(mvia),
        .move_linear_o(mlin), .fc_start_i(fcs), .fc_sel_i(fsel),
        .fc_feed_i(feed), .fc_busy_o(fb), .fc_valid_o(fval),
        .fc_div_zero_o(fdz), .fc_value_o(fv));
    pof_master_model u_master (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
        .set_i(set), .clr_i(clr), .release_i(rls), .new_sp_o(nsp));
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task tick;
        @(posedge sys_clk);
        #2;
    endtask : tick
    task chk(input string nm, input logic [36:0] e, input logic [36:0] s);
        comparisons++;
        if (e !== s) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task conclude;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude
    task acc(input logic w, input logic [15:0] i, input logic [7:0] s,
        input logic [31:0] d, input logic ab, input logic cd,
        input logic [31:0] e);
        od_q.push_back({cd, ab, e});
        req = 1;
        we = w;
        idx = i;
        sub = s;
        wd = d;
        tick;
        req = 0;
        tick;
    endtask : acc
    task fc(input logic [7:0] s, input logic [31:0] f, input logic [32:0] e);
        for (int i = 0; i < 40 && fb !== 1'b0; i++) tick;
        fc_q.push_back(e);
        fcs = 1;
        fsel = s;
        feed = f;
        tick;
        fcs = 0;
        tick;
    endtask : fc
    task sp(input logic [15:0] o, input logic r, input logic [31:0] t,
        input logic rj, input logic dp, input logic va);
        logic [31:0] e;
        e = o[1:0] == 2'b00 ? prev
            : (o[1:0] == 2'b01 ? RMP : ACT);
        e = r ? e + t : t;
        mv_q.push_back({rj, o[7:6] != 2'b11, va, o[7:6] == 2'b00, dp, e});
        acc(1, 16'h60F2, 8'h00, {16'h0000, o}, 0, 0, 0);
        rf = r;
        tgt = t;
        set = 1;
        tick;
        set = 0;
        for (int i = 0; i < 8 && sack !== 1'b1; i++) tick;
        if (rj || o[5:4] == 2'b00) begin
            tick;
            clr = 1;
            tick;
            clr = 0;
        end else if (o[5:4] == 2'b01) begin
            // Option rewritten mid-move; the latched copy must still rule
            acc(1, 16'h60F2, 8'h00, 0, 0, 0, 0);
            tick;
            tr = 1;
            for (int i = 0; i < 8 && rls !== 1'b1; i++) tick;
            tick;
            tr = 0;
        end
        for (int i = 0; i < 20 && {nsp, sack} !== 2'b00; i++) tick;
        chk("handshake", 0, {nsp, sack});
        tick;
        if (!rj) prev = e;
    endtask : sp
    always @(negedge sys_clk) begin
        if (rst_n && ack === 1'b1) begin
            on = od_q.pop_front();
            chk("abort", on[32], abt);
            if (on[33]) chk("rdata", on[31:0], rd);
        end
        if (rst_n && fval === 1'b1) begin
            fn = fc_q.pop_front();
            chk("feed", fn, {fdz, fv});
        end
        if (rst_n && (mv === 1'b1 || srej === 1'b1)) begin
            mn = mv_q.pop_front();
            chk("reject", mn[36], srej);
            if (!mn[36]) begin
                chk("target", mn[31:0], mtgt);
                chk("dir", mn[32], mdir);
                if (mn[35]) chk("via", mn[34], mvia);
                chk("linear", mn[33], mlin);
            end
        end
    end
    initial begin
        #(40 * 20000);
        failures++;
        conclude;
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        #2;
        rst_n = 1;
        acc(0, 16'h60EE, 8'h00, 0, 0, 1, 32'h3);
        acc(1, 16'h60EE, 8'h00, 5, 1, 1, 32'h3);
        acc(0, 16'h60F2, 8'h00, 0, 0, 1, 32'h1);
        for (int s = 1; s <= 3; s++) acc(0, 16'h60EE, s, 0, 0, 1, 1);
        acc(0, 16'h60EE, 8'h04, 0, 1, 1, 0);
        acc(0, 16'h60F2, 8'h01, 0, 1, 1, 0);
        acc(0, 16'h60F0, 8'h00, 0, 1, 1, 0);
        acc(1, 16'h60F2, 8'h00, 32'hABCD1235, 0, 0, 0);
        acc(0, 16'h60F2, 8'h00, 0, 0, 1, 32'h1235);
        for (int s = 1; s <= 3; s++) begin
            lf = lfsr(lf);
            rv[s] = {24'h000000, lf[7:0]} + 32'h1;
            acc(1, 16'h60EE, s, rv[s], 0, 0, 0);
            acc(0, 16'h60EE, s, 0, 0, 1, rv[s]);
        end
        for (int s = 1; s <= 3; s++) begin
            lf = lfsr(lf);
            fc(s, lf, {1'b0, lf / rv[s]});
        end
        acc(1, 16'h60EE, 8'h03, 0, 0, 0, 0);
        fc(3, 32'h1234, {1'b1, 32'hFFFFFFFF});
        sp(16'h0020, 1, 32'h2BC, 0, 0, 0);
        sp(16'h0021, 1, 32'h64, 0, 1, 0);
        sp(16'h0022, 1, 32'h64, 0, 1, 0);
        sp(16'h0020, 1, 32'h32, 0, 1, 0);
        sp(16'h0023, 1, 32'h5, 1, 0, 0);
        sp(16'h0030, 0, 32'h7D0, 1, 0, 0);
        sp(16'h0000, 0, 32'h7D0, 0, 1, 0);
        sp(16'h0010, 0, 32'h7D0, 0, 1, 0);
        sp(16'h0060, 0, 32'hBB8, 0, 0, 1);
        sp(16'h00A0, 0, 32'h1F4, 0, 1, 1);
        sp(16'h00E0, 0, 32'hBB8, 0, 0, 0);
        sp(16'h00E0, 0, 32'h7D0, 0, 1, 0);
        pp = 0;
        set = 1;
        tick;
        set = 0;
        repeat (4) tick;
        chk("mode gate", 0, sack);
        clr = 1;
        tick;
        clr = 0;
        pp = 1;
        tick;
        chk("pending", 0, od_q.size() + fc_q.size() + mv_q.size());
        conclude;
    end
endmodule : pof_top_test
